// ### pkg/pmcs_pkg.sv
// pmcs_pkg: constants and types of the power-mode clock switch
// assumes a 50 MHz system clock and a 32-bit APB register port
package pmcs_pkg;
  localparam int CLK_MHZ = 50;
  // register byte offsets
  localparam logic [7:0] OSC_CONTROL_OFS = 8'h00;
  localparam logic [7:0] AUX_TIMER_CONTROL_OFS = 8'h04;
  localparam logic [7:0] STRAP_STATUS_OFS = 8'h08;
  // osc_control_reg field positions
  localparam int IDLE_SELECT_BIT = 7;
  localparam int FREQ_LSB = 4;
  localparam int PRIMARY_READY_BIT = 3;
  localparam int INTERNAL_STABLE_BIT = 2;
  localparam int CLOCK_SELECT_LSB = 0;
  // aux_timer_control_reg field positions
  localparam int AUX_ENABLE_BIT = 0;
  localparam int AUX_ACTIVE_BIT = 1;
  // status register field positions
  localparam int STATE_LSB = 0;
  localparam int ACTIVE_SRC_LSB = 4;
  // reset values
  localparam logic [2:0] FREQ_RESET = 3'h3;
  localparam logic [1:0] CLOCK_SELECT_RESET = 2'h0;
  // half-cycle edges of each source counted on a switch
  localparam int SWITCH_HALF_EDGES = 5;
  // cpu_ready_delay
  localparam int CPU_READY_DELAY_NS = 2000;
  localparam int CPU_READY_CYCLES = (CPU_READY_DELAY_NS * CLK_MHZ + 999) / 1000;
  // slow internal oscillator half-period in system clocks
  localparam int SLOW_HALF_PERIOD = 200;
  typedef enum logic [1:0] {
    SRC_PRI = 2'h0,
    SRC_AUX = 2'h1,
    SRC_INT = 2'h2
  } pmcs_src_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SW_READY = 3'h1,
    ST_SW_OLD = 3'h2,
    ST_SW_NEW = 3'h3,
    ST_IDLE = 3'h4,
    ST_SLEEP = 3'h5,
    ST_WAKE_READY = 3'h6,
    ST_WAKE_DELAY = 3'h7
  } pmcs_state_t;
endpackage

// ### hw/pmcs_int_div.sv
// pmcs_int_div: half-cycle edge pulses of the internal oscillator block
// assumes freq_sel may change at any time; the new rate applies at once
`timescale 1ns/1ps
`default_nettype none
module pmcs_int_div import pmcs_pkg::*; #(
  parameter int SLOW_HALF = SLOW_HALF_PERIOD
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, low
  input wire logic [2:0] freq_sel, // internal frequency select
  output logic edge_out // one pulse per half cycle
);
  logic [7:0] cnt;
  logic [2:0] last_sel;
  logic [7:0] term;
  // terminal count: slow source for zero, else powers of two
  always_comb begin
    if (freq_sel == 3'h0) begin
      term = 8'(SLOW_HALF - 1);
    end else begin
      term = 8'((9'h1 << (3'h7 - freq_sel)) - 9'h1);
    end
  end
  // counter restarts on a frequency change
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 8'h00;
      last_sel <= FREQ_RESET;
      edge_out <= 1'b0;
    end else begin
      last_sel <= freq_sel;
      edge_out <= (cnt >= term) || (freq_sel != last_sel);
      if ((cnt >= term) || (freq_sel != last_sel)) begin
        cnt <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/pmcs_edge_count.sv
// pmcs_edge_count: counts a fixed number of edge pulses after a start
// assumes start is not raised while a count is running
`timescale 1ns/1ps
`default_nettype none
module pmcs_edge_count import pmcs_pkg::*; #(
  parameter int EDGES = SWITCH_HALF_EDGES
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, low
  input wire logic start, // begin a count
  input wire logic edge_in, // source half-cycle pulse
  output logic done // pulse when count reached
);
  logic busy;
  logic [3:0] cnt;
  // count edges until the target is met
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt <= 4'h0;
      end else if (busy && edge_in) begin
        if (cnt == 4'(EDGES - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/pmcs_ctrl.sv
// pmcs_ctrl: power-mode and system clock switch controller, APB slave
// assumes oscillator edge pulses and ready levels synchronous to clk
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmcs_ctrl import pmcs_pkg::*; #(
  parameter int DELAY_CYCLES = CPU_READY_CYCLES,
  parameter int HALF_EDGES = SWITCH_HALF_EDGES,
  parameter int SLOW_HALF = SLOW_HALF_PERIOD
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic sleep_req, // cpu sleep request pulse
  input wire logic wake_irq, // interrupt wake pulse
  input wire logic wake_wdt, // watchdog time-out pulse
  input wire logic two_speed_en, // two-speed start-up strap
  input wire logic fail_safe_en, // fail-safe monitor strap
  input wire logic wdt_select, // watchdog selected
  input wire logic primary_is_internal, // primary is fast internal
  input wire logic primary_edge, // primary half-cycle pulse
  input wire logic primary_ready, // primary oscillator ready
  input wire logic aux_edge, // aux half-cycle pulse
  input wire logic aux_ready, // aux oscillator ready
  input wire logic fast_int_stable, // fast internal stable
  output logic cpu_clk_en, // cpu clock enable
  output logic periph_clk_en, // peripheral clock enable
  output logic primary_osc_en, // primary oscillator run
  output logic aux_osc_en, // aux oscillator run
  output logic internal_osc_en, // fast internal run
  output logic slow_osc_en, // slow internal run
  output logic primary_ready_flag, // status flag
  output logic internal_stable_flag, // status flag
  output logic aux_osc_active_flag // status flag
);
  pmcs_state_t state;
  pmcs_src_t act_src;
  pmcs_src_t new_src;
  logic idle_select;
  logic [2:0] internal_freq_select;
  logic [1:0] clock_select;
  logic aux_osc_enable;
  logic boot_done;
  logic [15:0] dly;
  logic int_edge;
  logic cnt_start;
  logic cnt_done;
  logic cnt_edge;
  logic wake;
  pmcs_src_t tgt;
  logic [2:0] next_flags;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] rd_word;
  logic rd_err;

  // source chosen by clock_select
  function automatic pmcs_src_t sel_to_src(input logic [1:0] sel);
    if (sel[1]) begin
      sel_to_src = SRC_INT;
    end else if (sel[0]) begin
      sel_to_src = SRC_AUX;
    end else begin
      sel_to_src = SRC_PRI;
    end
  endfunction

  // half-cycle pulse of a source
  function automatic logic src_edge(input pmcs_src_t s, input logic pe, input logic ae, input logic ie);
    if (s == SRC_PRI) begin
      src_edge = pe;
    end else if (s == SRC_AUX) begin
      src_edge = ae;
    end else begin
      src_edge = ie;
    end
  endfunction

  // readiness of a source
  function automatic logic src_ready(input pmcs_src_t s, input logic pr, input logic ar, input logic aen);
    if (s == SRC_PRI) begin
      src_ready = pr;
    end else if (s == SRC_AUX) begin
      src_ready = ar && aen;
    end else begin
      src_ready = 1'b1;
    end
  endfunction

  // flag pattern for a source driving the clock
  function automatic logic [2:0] src_flags(input pmcs_src_t s, input logic pint, input logic fst,
                                            input logic [2:0] fq);
    if (s == SRC_PRI) begin
      src_flags = {1'b1, pint && fst, 1'b0};
    end else if (s == SRC_AUX) begin
      src_flags = 3'h1;
    end else begin
      src_flags = {1'b0, fst && (fq != 3'h0), 1'b0};
    end
  endfunction

  assign tgt = sel_to_src(clock_select);
  assign wake = wake_irq || wake_wdt;
  assign cnt_start = ((state == ST_SW_READY) && src_ready(new_src, primary_ready, aux_ready, aux_osc_enable))
                     || ((state == ST_SW_OLD) && cnt_done);
  assign cnt_edge = (state == ST_SW_OLD) ? src_edge(act_src, primary_edge, aux_edge, int_edge)
                                         : src_edge(new_src, primary_edge, aux_edge, int_edge);

  // internal oscillator block edge generator
  pmcs_int_div #(
    .SLOW_HALF(SLOW_HALF)
  ) u_div (
    .clk(clk),
    .resetn(resetn),
    .freq_sel(internal_freq_select),
    .edge_out(int_edge)
  );

  // counts old and new source half cycles of a switch
  pmcs_edge_count #(
    .EDGES(HALF_EDGES)
  ) u_cnt (
    .clk(clk),
    .resetn(resetn),
    .start(cnt_start),
    .edge_in(cnt_edge),
    .done(cnt_done)
  );

  // apb access decode
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_rd = psel && penable && !pready && !pwrite;

  // read mux, unmapped addresses answer an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == OSC_CONTROL_OFS) begin
      rd_word[IDLE_SELECT_BIT] = idle_select;
      rd_word[FREQ_LSB +: 3] = internal_freq_select;
      rd_word[PRIMARY_READY_BIT] = primary_ready_flag;
      rd_word[INTERNAL_STABLE_BIT] = internal_stable_flag;
      rd_word[CLOCK_SELECT_LSB +: 2] = clock_select;
    end else if (paddr == AUX_TIMER_CONTROL_OFS) begin
      rd_word[AUX_ENABLE_BIT] = aux_osc_enable;
      rd_word[AUX_ACTIVE_BIT] = aux_osc_active_flag;
    end else if (paddr == STRAP_STATUS_OFS) begin
      rd_word[STATE_LSB +: 3] = state;
      rd_word[ACTIVE_SRC_LSB +: 2] = act_src;
    end else begin
      rd_err = 1'b1;
    end
  end

  // apb handshake: one wait state, ready in the second access cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && rd_err;
      if (apb_rd) begin
        prdata <= rd_word;
      end
    end
  end

  // software control bits; wake events never touch them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_select <= 1'b0;
      internal_freq_select <= FREQ_RESET;
      clock_select <= CLOCK_SELECT_RESET;
      aux_osc_enable <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == OSC_CONTROL_OFS) begin
        idle_select <= pwdata[IDLE_SELECT_BIT];
        internal_freq_select <= pwdata[FREQ_LSB +: 3];
        clock_select <= pwdata[CLOCK_SELECT_LSB +: 2];
      end else if (paddr == AUX_TIMER_CONTROL_OFS) begin
        aux_osc_enable <= pwdata[AUX_ENABLE_BIT];
      end
    end
  end

  // mode sequencer and active source
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RUN;
      act_src <= SRC_PRI;
      new_src <= SRC_PRI;
      boot_done <= 1'b0;
      dly <= 16'h0000;
    end else begin
      case (state)
        ST_RUN: begin
          if (!boot_done) begin
            boot_done <= 1'b1;
            if (two_speed_en) begin
              act_src <= SRC_INT;
            end
          end else if (sleep_req) begin
            if (idle_select) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_SLEEP;
            end
          end else if ((tgt != act_src) && !((tgt == SRC_AUX) && !aux_osc_enable)) begin
            new_src <= tgt;
            state <= ST_SW_READY;
          end
        end
        ST_SW_READY: begin
          if (src_ready(new_src, primary_ready, aux_ready, aux_osc_enable)) begin
            state <= ST_SW_OLD;
          end
        end
        ST_SW_OLD: begin
          if (cnt_done) begin
            state <= ST_SW_NEW;
          end
        end
        ST_SW_NEW: begin
          if (cnt_done) begin
            act_src <= new_src;
            state <= ST_RUN;
          end
        end
        ST_IDLE: begin
          if (wake) begin
            dly <= 16'h0000;
            state <= ST_WAKE_DELAY;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            state <= ST_WAKE_READY;
          end
        end
        ST_WAKE_READY: begin
          dly <= 16'h0000;
          if (two_speed_en || fail_safe_en) begin
            act_src <= SRC_INT;
            state <= ST_WAKE_DELAY;
          end else if (src_ready(tgt, primary_ready, aux_ready, aux_osc_enable)) begin
            act_src <= tgt;
            state <= ST_WAKE_DELAY;
          end
        end
        ST_WAKE_DELAY: begin
          if (dly == 16'(DELAY_CYCLES - 1)) begin
            state <= ST_RUN;
          end else begin
            dly <= dly + 16'h0001;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // flag value for the next cycle
  always_comb begin
    next_flags = {primary_ready_flag, internal_stable_flag, aux_osc_active_flag};
    if ((state == ST_RUN) && boot_done && sleep_req && !idle_select) begin
      next_flags = 3'h0;
    end else if ((state == ST_SW_NEW) && cnt_done) begin
      next_flags = src_flags(new_src, primary_is_internal, fast_int_stable, internal_freq_select);
    end else if (state == ST_RUN) begin
      next_flags = src_flags(act_src, primary_is_internal, fast_int_stable, internal_freq_select);
    end else if (state == ST_WAKE_DELAY) begin
      next_flags = src_flags(act_src, primary_is_internal, fast_int_stable, internal_freq_select);
    end
  end

  // status flags, held through idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primary_ready_flag <= 1'b0;
      internal_stable_flag <= 1'b0;
      aux_osc_active_flag <= 1'b0;
    end else begin
      primary_ready_flag <= next_flags[2];
      internal_stable_flag <= next_flags[1];
      aux_osc_active_flag <= next_flags[0];
    end
  end

  // registered clock enables from the active source edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      cpu_clk_en <= src_edge(act_src, primary_edge, aux_edge, int_edge)
                    && (state inside {ST_RUN, ST_SW_READY, ST_SW_OLD, ST_SW_NEW});
      periph_clk_en <= src_edge(act_src, primary_edge, aux_edge, int_edge)
                       && !(state inside {ST_SLEEP, ST_WAKE_READY});
    end
  end

  // oscillator run controls
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      primary_osc_en <= 1'b1;
      aux_osc_en <= 1'b0;
      internal_osc_en <= 1'b0;
      slow_osc_en <= 1'b0;
    end else begin
      primary_osc_en <= ((act_src == SRC_PRI) && !(state inside {ST_SLEEP, ST_WAKE_READY}))
                        || ((state inside {ST_SW_READY, ST_SW_OLD, ST_SW_NEW}) && (new_src == SRC_PRI))
                        || ((state == ST_WAKE_READY) && (tgt == SRC_PRI));
      aux_osc_en <= aux_osc_enable;
      internal_osc_en <= (state != ST_SLEEP) && ((act_src == SRC_INT) || (new_src == SRC_INT)
                         || (state == ST_WAKE_READY));
      slow_osc_en <= wdt_select || ((state != ST_SLEEP) && (act_src == SRC_INT)
                     && (internal_freq_select == 3'h0));
    end
  end
endmodule
`default_nettype wire

// ### tb/pmcs_ctrl_monitor.sv
// pmcs_ctrl_monitor: concurrent checks on the clock switch ports
// assumes one clock domain and a bench that keeps the apb and sleep rules
`timescale 1ns/1ps
`default_nettype none
module pmcs_ctrl_monitor import pmcs_pkg::*; (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic sleep_req, // sleep pulse
  input wire logic wake_irq, // irq wake
  input wire logic wake_wdt, // watchdog wake
  input wire logic aux_ready, // aux ready
  input wire logic cpu_clk_en, // cpu enable
  input wire logic periph_clk_en, // peripheral enable
  input wire logic primary_osc_en, // primary run
  input wire logic aux_osc_en, // aux run
  input wire logic primary_ready_flag, // flag
  input wire logic internal_stable_flag, // flag
  input wire logic aux_osc_active_flag // flag
);
  logic idle_q, aux_en_q, osc_wr, wake;
  logic [1:0] mode_q;
  logic [2:0] flags;
  // completed osc_control_reg writes, the wake pulse and the flag triple
  assign osc_wr = psel && penable && pready && pwrite && (paddr == OSC_CONTROL_OFS);
  assign wake = wake_irq || wake_wdt;
  assign flags = {primary_ready_flag, internal_stable_flag, aux_osc_active_flag};
  // shadow of software bits and of the mode: 0 run, 1 idle, 2 sleep
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_q <= 1'b0;
      aux_en_q <= 1'b0;
      mode_q <= 2'd0;
    end else begin
      if (osc_wr) idle_q <= pwdata[IDLE_SELECT_BIT];
      if (psel && penable && pready && pwrite && paddr == AUX_TIMER_CONTROL_OFS) aux_en_q <= pwdata[AUX_ENABLE_BIT];
      if (wake) mode_q <= 2'd0;
      else if (sleep_req && mode_q == 2'd0) mode_q <= idle_q ? 2'd1 : 2'd2;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_FLAG_CODE: assert property (!(aux_osc_active_flag && (primary_ready_flag || internal_stable_flag)))
    else $error("aux flag shown with another source flag");
  AST_CPU_PERIPH: assert property (cpu_clk_en |-> periph_clk_en)
    else $error("cpu clocked without peripherals");
  AST_PRI_FLAG: assert property (primary_ready_flag |-> primary_osc_en)
    else $error("primary flag with primary stopped");
  AST_AUX_ENTRY: assert property ($rose(aux_osc_active_flag) |-> aux_en_q && aux_ready && !primary_ready_flag ##[0:2] !primary_osc_en)
    else $error("bad entry to aux run");
  AST_AUX_RUNS: assert property (aux_en_q [*3] |-> aux_osc_en)
    else $error("aux oscillator stopped while enabled");
  AST_SLEEP: assert property (sleep_req && !idle_q && mode_q == 2'd0 |=> flags == 3'h0 ##2 (!cpu_clk_en && !periph_clk_en && !primary_osc_en) [*4])
    else $error("sleep left a clock or flag running");
  AST_IDLE: assert property (sleep_req && idle_q && mode_q == 2'd0 |=> $stable(flags) ##1 (!cpu_clk_en) [*4] ##[0:20] periph_clk_en)
    else $error("idle entry wrong");
  AST_IDLE_WAKE: assert property (wake && mode_q == 2'd1 |=> (!cpu_clk_en) [*4] ##[1:40] cpu_clk_en)
    else $error("idle wake delay wrong");
  AST_SLEEP_WAKE: assert property (wake && mode_q == 2'd2 |-> ##[1:300] cpu_clk_en)
    else $error("no run after sleep wake");
  AST_SWITCH_LEN: assert property (osc_wr && pwdata[1:0] != 2'b00 && flags == 3'b100 |=> $stable(flags) [*8])
    else $error("switch finished too early");
  AST_AUX_SWITCH: assert property (osc_wr && pwdata[1:0] == 2'b01 && aux_en_q && aux_ready && flags == 3'b100
    |=> ##[1:300] aux_osc_active_flag)
    else $error("switch to running aux did not happen");
  COV_SLEEP: cover property (sleep_req && !idle_q && mode_q == 2'd0);
  COV_IDLE_WAKE: cover property (wake && mode_q == 2'd1);
  COV_AUX: cover property ($rose(aux_osc_active_flag));
endmodule
bind pmcs_ctrl pmcs_ctrl_monitor u_mon (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .sleep_req, .wake_irq, .wake_wdt, .aux_ready, .cpu_clk_en, .periph_clk_en, .primary_osc_en, .aux_osc_en,
  .primary_ready_flag, .internal_stable_flag, .aux_osc_active_flag);
`default_nettype wire

// ### tb/pmcs_osc_one.sv
// pmcs_osc_one: one oscillator source as seen by the clock switch
// assumes run comes from the controller; pulses stand still while it is low
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_one #(
  parameter int HALF = 3,
  parameter int START = 16
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, low
  input wire logic run, // oscillator enable
  output logic ready, // started and stable
  output logic edge_pls // one pulse per half cycle
);
  int cnt, ph;
  // start-up count, then the half-cycle phase; both clear when stopped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      ph <= 0;
    end else begin
      cnt <= run ? ((cnt < START) ? cnt + 1 : cnt) : 0;
      ph <= (run && ph < HALF - 1) ? ph + 1 : 0;
    end
  end
  // ready only after start-up, so a slow start really delays the switch
  assign ready = (cnt >= START);
  assign edge_pls = ready && (ph == 0);
endmodule
`default_nettype wire

// ### tb/tb_pmcs_ctrl.sv
// tb_pmcs_ctrl: self-checking bench of the power-mode clock switch
// assumes pmcs_osc_one for the oscillators and the handed-over apb timing
`timescale 1ns/1ps
`default_nettype none
module tb_pmcs_ctrl import pmcs_pkg::*; ;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sleep_req, wake_irq, wake_wdt, two_speed_en, fail_safe_en, wdt_select, primary_is_internal;
  logic primary_edge, primary_ready, aux_edge, aux_ready, fast_int_stable, int_rdy;
  logic cpu_clk_en, periph_clk_en, primary_osc_en, aux_osc_en, internal_osc_en, slow_osc_en;
  logic primary_ready_flag, internal_stable_flag, aux_osc_active_flag;
  logic [2:0] flags;
  int failures, cmp_count;
  assign flags = {primary_ready_flag, internal_stable_flag, aux_osc_active_flag};
  // design with shortened cpu delay and slow-oscillator counts
  pmcs_ctrl #(.DELAY_CYCLES(4), .SLOW_HALF(4)) u_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_req, .wake_irq, .wake_wdt, .two_speed_en, .fail_safe_en,
    .wdt_select, .primary_is_internal, .primary_edge, .primary_ready, .aux_edge, .aux_ready,
    .fast_int_stable, .cpu_clk_en, .periph_clk_en, .primary_osc_en, .aux_osc_en, .internal_osc_en,
    .slow_osc_en, .primary_ready_flag, .internal_stable_flag, .aux_osc_active_flag);
  // oscillators: fast primary, slow-starting aux, fast internal
  pmcs_osc_one #(.HALF(3), .START(16)) u_pri (.clk, .resetn, .run(primary_osc_en), .ready(primary_ready),
    .edge_pls(primary_edge));
  pmcs_osc_one #(.HALF(5), .START(30)) u_aux (.clk, .resetn, .run(aux_osc_en), .ready(aux_ready),
    .edge_pls(aux_edge));
  pmcs_osc_one #(.HALF(2), .START(8)) u_int (.clk, .resetn, .run(internal_osc_en), .ready(int_rdy),
    .edge_pls());
  // an internal primary reports its stability through the primary's readiness
  assign fast_int_stable = primary_is_internal ? primary_ready : int_rdy;
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) failures++;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  function automatic logic [31:0] oc(input logic i, input logic [2:0] f, input logic [1:0] fl, input logic [1:0] s);
    return (32'(i) << IDLE_SELECT_BIT) | (32'(f) << FREQ_LSB) | (32'(fl) << INTERNAL_STABLE_BIT) | 32'(s);
  endfunction
  task automatic wflags(input logic [2:0] exp, input int lim);
    int n;
    n = 0;
    while (flags !== exp && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(32'(flags), 32'(exp));
  endtask
  // one-cycle pulse: 0 sleep, 1 interrupt, 2 watchdog
  task automatic ev(input int k);
    if (k == 0) sleep_req <= 1'b1;
    else if (k == 1) wake_irq <= 1'b1;
    else wake_wdt <= 1'b1;
    @(posedge clk);
    {sleep_req, wake_irq, wake_wdt} <= 3'b000;
  endtask
  task automatic pulses(input int len, output int c, output int p);
    c = 0;
    p = 0;
    repeat (len) begin
      @(posedge clk);
      c += int'(cpu_clk_en === 1'b1);
      p += int'(periph_clk_en === 1'b1);
    end
  endtask
  task automatic gap(output int g);
    int k;
    k = 0;
    while (periph_clk_en !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    g = 1;
    while (periph_clk_en !== 1'b1 && g < 300) begin
      @(posedge clk);
      g++;
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    int c, p, g;
    {clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_req, wake_irq, wake_wdt, two_speed_en, fail_safe_en, primary_is_internal} = '0;
    wdt_select = 1'b1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (40) @(posedge clk);
    rdc(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b10, CLOCK_SELECT_RESET));
    rdc(AUX_TIMER_CONTROL_OFS, 32'h0);
    rdc(STRAP_STATUS_OFS, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    wr(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b01, 2'b00));
    rdc(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b10, 2'b00));
    wr(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b00, 2'b01));
    repeat (100) @(posedge clk);
    chk(32'(flags), 32'h4);
    wr(AUX_TIMER_CONTROL_OFS, 32'h1 << AUX_ENABLE_BIT);
    wflags(3'b001, 400);
    @(posedge clk);
    chk(32'(primary_osc_en), 32'h0);
    rdc(AUX_TIMER_CONTROL_OFS, (32'h1 << AUX_ENABLE_BIT) | (32'h1 << AUX_ACTIVE_BIT));
    wr(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b00, 2'b00));
    chk(32'(flags), 32'h1);
    wflags(3'b100, 400);
    chk(32'(aux_osc_en), 32'h1);
    wr(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b00, 2'b01));
    wflags(3'b001, 400);
    wr(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b00, 2'b00));
    wflags(3'b100, 400);
    wr(OSC_CONTROL_OFS, oc(1'b0, FREQ_RESET, 2'b00, 2'b11));
    wflags(3'b010, 400);
    @(posedge clk);
    chk(32'(primary_osc_en), 32'h0);
    for (int f = 4; f < 8; f++) begin
      wr(OSC_CONTROL_OFS, oc(1'b0, 3'(f), 2'b00, 2'b11));
      gap(g);
      gap(g);
      chk(32'(g), 32'(1 << (7 - f)));
    end
    wr(OSC_CONTROL_OFS, oc(1'b0, 3'h7, 2'b00, 2'b00));
    chk(32'(flags), 32'h2);
    wflags(3'b100, 400);
    // idle, with idle_select cleared while idle
    wr(OSC_CONTROL_OFS, oc(1'b1, 3'h7, 2'b00, 2'b00));
    ev(0);
    wr(OSC_CONTROL_OFS, oc(1'b0, 3'h7, 2'b00, 2'b00));
    pulses(30, c, p);
    chk(32'(c), 32'h0);
    chk(32'(p > 0), 32'h1);
    chk(32'(flags), 32'h4);
    rdc(STRAP_STATUS_OFS, 32'(ST_IDLE));
    ev(1);
    pulses(4, c, p);
    chk(32'(c), 32'h0);
    pulses(30, c, p);
    chk(32'(c > 0), 32'h1);
    rdc(OSC_CONTROL_OFS, oc(1'b0, 3'h7, 2'b10, 2'b00));
    // sleep, woken by the watchdog; the pulse launched at the sleep edge is skipped
    ev(0);
    @(posedge clk);
    pulses(20, c, p);
    chk(32'(c + p), 32'h0);
    chk(32'(flags), 32'h0);
    chk(32'({primary_osc_en, aux_osc_en, slow_osc_en}), 32'h3);
    ev(2);
    wflags(3'b100, 400);
    pulses(20, c, p);
    chk(32'(c > 0), 32'h1);
    rdc(OSC_CONTROL_OFS, oc(1'b0, 3'h7, 2'b10, 2'b00));
    // sleep wakes with two-speed, then fail-safe with an internal primary, first from the internal block
    for (int k = 0; k < 2; k++) begin
      {two_speed_en, fail_safe_en, wdt_select, primary_is_internal} <= {k == 0, k == 1, 1'b0, k == 1};
      ev(0);
      repeat (10) @(posedge clk);
      chk(32'({internal_osc_en, slow_osc_en}), 32'h0);
      ev(1);
      apb(1'b0, STRAP_STATUS_OFS, 32'h0, r, e);
      chk(32'(r[5:4]), 32'(SRC_INT));
      wflags({2'(k + 2), 1'b0}, 600);
    end
    stop_test();
  end
endmodule
`default_nettype wire
